// ### design/snp_top.sv
// Behaviour
// - programming only while reset pin low
// - enable command before any program or erase
// - eeprom byte write erases location itself
// - chip erase fills flash and eeprom 0xFF
// - input bits sampled on sck rising edge
// - output bits shifted on sck falling edge
// - echo 0x53 during third enable byte
// - flash page of 16 words, low index
// - page write uses upper five address bits
// - eeprom byte write, 4.0 ms wait
// - eeprom page buffer four bytes, page select
// - eeprom page write touches loaded bytes only
// - read command returns stored content
// - reset pin high leaves programming mode
// - enable is 0xAC 0x53 plus two bytes
// - poll returns busy bit in last byte
`timescale 1ns/1ns
`default_nettype none
module snp_top #(
  parameter int FL_WORDS = snp_pkg::FLASH_WORDS,
  parameter int FL_PAGE = snp_pkg::FLASH_PAGE_WORDS,
  parameter int EE_SIZE = snp_pkg::EE_BYTES,
  parameter int EE_PAGE = snp_pkg::EE_PAGE_BYTES,
  parameter int FLASH_WAIT = snp_pkg::FLASH_WAIT_CYC,
  parameter int EEPROM_WAIT = snp_pkg::EEPROM_WAIT_CYC,
  parameter int ERASE_WAIT = snp_pkg::ERASE_WAIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic prog_rst_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_en_o,
  output logic prog_mode_o,
  output logic busy_o,
  output logic normal_run_o
);
  import snp_pkg::*;

  localparam int FL_AW = $clog2(FL_WORDS);
  localparam int PG_AW = $clog2(FL_PAGE);
  localparam int EE_AW = $clog2(EE_SIZE);
  localparam int EP_AW = $clog2(EE_PAGE);

  function automatic logic op_is(input logic [7:0] b, input logic [7:0] op);
    // the half-select bit is a don't-care for the match
    return (b & ~HALF_SEL) == op;
  endfunction : op_is

  function automatic logic agreed_change(input logic [2:0] s, input logic seen);
    return (s[1] == s[2]) && (s[2] != seen);
  endfunction : agreed_change

  snp_cmd_s cmd;
  logic hdr_tgl;
  logic cmd_tgl;
  logic [7:0] rd_byte;

  snp_link u_link (
    .sck_i(sck_i),
    .prog_rst_n_i(prog_rst_n_i),
    .mosi_i(mosi_i),
    .rd_byte_i(rd_byte),
    .cmd_o(cmd),
    .hdr_tgl_o(hdr_tgl),
    .cmd_tgl_o(cmd_tgl),
    .miso_o(miso_o)
  );

  logic [2:0] pin_s;
  logic [2:0] hdr_s;
  logic [2:0] cmd_s;
  logic pin_seen;
  logic hdr_seen;
  logic cmd_seen;
  logic pin_low_now;
  logic hdr_evt;
  logic cmd_evt;

  // three stages on the pin and both toggles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s <= 3'h7;
      hdr_s <= 3'h0;
      cmd_s <= 3'h0;
    end else begin
      pin_s <= {pin_s[1:0], prog_rst_n_i};
      hdr_s <= {hdr_s[1:0], hdr_tgl};
      cmd_s <= {cmd_s[1:0], cmd_tgl};
    end
  end

  // toggles need sck phases longer than two clk cycles to be seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_seen <= 1'b1;
      hdr_seen <= 1'b0;
      cmd_seen <= 1'b0;
    end else begin
      if (pin_s[1] == pin_s[2]) begin
        pin_seen <= pin_s[2];
      end
      if (hdr_s[1] == hdr_s[2]) begin
        hdr_seen <= hdr_s[2];
      end
      if (cmd_s[1] == cmd_s[2]) begin
        cmd_seen <= cmd_s[2];
      end
    end
  end

  // the link clears its toggles when the pin rises; pin_low_now drops once stage one
  // sees the pin high, a cycle before the toggle stages agree, which masks that false event
  assign pin_low_now = !pin_s[1] && !pin_s[2];
  assign hdr_evt = agreed_change(hdr_s, hdr_seen) && pin_low_now;
  assign cmd_evt = agreed_change(cmd_s, cmd_seen) && pin_low_now;

  logic prog_en;
  snp_state_e state;
  logic [FL_AW-1:0] erase_idx;
  logic [WAIT_W-1:0] wait_cnt;
  logic busy;
  logic do_en;
  logic exec;
  logic wr_ok;
  logic do_erase;
  logic do_ld_fl;
  logic do_wr_fl;
  logic do_wr_ee;
  logic do_ld_ee;
  logic do_wr_eep;
  logic do_any_wr;
  assign busy = state != ST_IDLE;
  assign do_en = cmd_evt && cmd.b1 == OP_ENABLE && cmd.b2 == OP_ENABLE_B2;
  assign exec = cmd_evt && prog_en;
  assign wr_ok = exec && !busy;
  assign do_erase = wr_ok && cmd.b1 == OP_ENABLE && cmd.b2[7:5] == ERASE_TAG;
  assign do_ld_fl = wr_ok && op_is(cmd.b1, OP_LD_FLASH);
  assign do_wr_fl = wr_ok && cmd.b1 == OP_WR_FLASH;
  assign do_wr_ee = wr_ok && cmd.b1 == OP_WR_EE;
  assign do_ld_ee = wr_ok && cmd.b1 == OP_LD_EE;
  assign do_wr_eep = wr_ok && cmd.b1 == OP_WR_EE_PAGE;
  assign do_any_wr = do_erase || do_wr_fl || do_wr_ee || do_wr_eep;

  // enable only counts while the pin is low and is lost when it rises
  always_ff @(posedge clk_i) begin
    if (rst_i || !pin_low_now) begin
      prog_en <= 1'b0;
    end else if (do_en) begin
      prog_en <= 1'b1;
    end
  end
  logic [15:0] fl_sel;
  logic [FL_AW-1:0] fl_addr;
  logic [PG_AW-1:0] fl_word;
  logic [FL_AW-PG_AW-1:0] fl_page;
  logic [EE_AW-1:0] ee_addr;
  logic [EP_AW-1:0] ee_word;
  logic [EE_AW-EP_AW-1:0] ee_page;
  logic half_hi;
  assign fl_sel = {cmd.b2, cmd.b3};
  assign fl_addr = fl_sel[FL_AW-1:0];
  assign fl_word = cmd.b3[PG_AW-1:0];
  assign fl_page = fl_addr[FL_AW-1:PG_AW];
  assign ee_addr = cmd.b3[EE_AW-1:0];
  assign ee_word = cmd.b3[EP_AW-1:0];
  assign ee_page = ee_addr[EE_AW-1:EP_AW];
  assign half_hi = (cmd.b1 & HALF_SEL) != 8'h00;

  // self-timed operations: erase walks the arrays, then a fixed wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      erase_idx <= '0;
      wait_cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (do_erase) begin
            state <= ST_ERASE;
            erase_idx <= '0;
          end else if (do_wr_fl) begin
            state <= ST_WAIT;
            wait_cnt <= WAIT_W'(FLASH_WAIT - 1);
          end else if (do_wr_ee || do_wr_eep) begin
            state <= ST_WAIT;
            wait_cnt <= WAIT_W'(EEPROM_WAIT - 1);
          end
        end
        ST_ERASE: begin
          erase_idx <= erase_idx + 1'b1;
          if (erase_idx == FL_AW'(FL_WORDS - 1)) begin
            state <= ST_WAIT;
            wait_cnt <= WAIT_W'(ERASE_WAIT - 1);
          end
        end
        ST_WAIT: begin
          if (wait_cnt == '0) begin
            state <= ST_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  logic [15:0] flash_mem [FL_WORDS];
  logic [15:0] flash_buf [FL_PAGE];
  logic [7:0] ee_mem [EE_SIZE];
  logic [7:0] ee_buf [EE_PAGE];
  logic [EE_PAGE-1:0] ee_mask;
  // buffer keeps its words after a commit, as the programmer may reuse them
  always_ff @(posedge clk_i) begin
    if (do_ld_fl) begin
      if (half_hi) begin
        flash_buf[fl_word][15:8] <= cmd.b4;
      end else begin
        flash_buf[fl_word][7:0] <= cmd.b4;
      end
    end
  end

  // erase assumes the flash is at least as deep as the eeprom
  always_ff @(posedge clk_i) begin
    if (state == ST_ERASE) begin
      flash_mem[erase_idx] <= {ERASED_BYTE, ERASED_BYTE};
    end else if (do_wr_fl) begin
      for (int i = 0; i < FL_PAGE; i++) begin
        flash_mem[{fl_page, PG_AW'(i)}] <= flash_buf[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_ld_ee) begin
      ee_buf[ee_word] <= cmd.b4;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || do_wr_eep) begin
      ee_mask <= '0;
    end else if (do_ld_ee) begin
      ee_mask[ee_word] <= 1'b1;
    end
  end

  // a byte write simply replaces the cell: erase is folded into it
  always_ff @(posedge clk_i) begin
    if (state == ST_ERASE) begin
      ee_mem[erase_idx[EE_AW-1:0]] <= ERASED_BYTE;
    end else if (do_wr_ee) begin
      ee_mem[ee_addr] <= cmd.b4;
    end else if (do_wr_eep) begin
      for (int i = 0; i < EE_PAGE; i++) begin
        if (ee_mask[i]) begin
          ee_mem[{ee_page, EP_AW'(i)}] <= ee_buf[i];
        end
      end
    end
  end

  // read data is fetched once three bytes are in and held for byte four
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_byte <= 8'h00;
    end else if (hdr_evt) begin
      if (!prog_en) begin
        rd_byte <= 8'h00;
      end else if (op_is(cmd.b1, OP_RD_FLASH)) begin
        rd_byte <= half_hi ? flash_mem[fl_addr][15:8] : flash_mem[fl_addr][7:0];
      end else if (cmd.b1 == OP_RD_EE) begin
        rd_byte <= ee_mem[ee_addr];
      end else if (cmd.b1 == OP_POLL) begin
        rd_byte <= {7'h00, busy};
      end else begin
        rd_byte <= 8'h00;
      end
    end
  end

  assign miso_en_o = !pin_seen;
  assign normal_run_o = pin_seen;
  assign prog_mode_o = prog_en;
  assign busy_o = busy;

  logic [7:0] chk_old;
  always_ff @(posedge clk_i) begin
    chk_old <= ee_mem[{ee_page, EP_AW'(1)}];
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_exec_gate;
    do_any_wr |-> prog_en && pin_low_now;
  endproperty
  a_exec_gate: assert property (p_exec_gate) else $error("write without enable");

  property p_pin_only;
    do_any_wr |-> !pin_seen;
  endproperty
  a_pin_only: assert property (p_pin_only) else $error("write with pin high");

  property p_leave;
    !pin_low_now |=> !prog_en ##1 !prog_en;
  endproperty
  a_leave: assert property (p_leave) else $error("enable kept after pin rise");

  property p_enable;
    do_en && pin_low_now |=> prog_en;
  endproperty
  a_enable: assert property (p_enable) else $error("enable not taken");

  property p_ignore_busy;
    state == ST_WAIT && cmd_evt && cmd.b1 == OP_WR_EE
      |=> ee_mem[$past(ee_addr)] == $past(ee_mem[ee_addr]);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("write taken while busy");

  property p_ee_byte;
    do_wr_ee |=> (ee_mem[$past(ee_addr)] == $past(cmd.b4)) ##0 busy[*8];
  endproperty
  a_ee_byte: assert property (p_ee_byte) else $error("eeprom byte not written");

  property p_fl_commit;
    do_wr_fl |=> flash_mem[{$past(fl_page), PG_AW'(0)}] == $past(flash_buf[0]);
  endproperty
  a_fl_commit: assert property (p_fl_commit) else $error("flash page not committed");

  property p_ee_keep;
    do_wr_eep && !ee_mask[1] |=> ee_mem[{$past(ee_page), EP_AW'(1)}] == chk_old;
  endproperty
  a_ee_keep: assert property (p_ee_keep) else $error("unloaded eeprom byte changed");

  property p_erase_done;
    state == ST_ERASE && erase_idx == FL_AW'(FL_WORDS - 1)
      |=> flash_mem[0] == {ERASED_BYTE, ERASED_BYTE} && ee_mem[0] == ERASED_BYTE
          && state == ST_WAIT;
  endproperty
  a_erase_done: assert property (p_erase_done) else $error("erase left data");

  property p_poll;
    hdr_evt && prog_en && cmd.b1 == OP_POLL |=> rd_byte == {7'h00, $past(busy)};
  endproperty
  a_poll: assert property (p_poll) else $error("poll result wrong");

  c_enable: cover property ($rose(prog_en));
  c_erase: cover property (do_erase ##1 state == ST_ERASE);
  c_flash: cover property (do_ld_fl ##[1:1000] do_wr_fl);
  c_eepage: cover property (do_ld_ee ##[1:1000] do_wr_eep);

endmodule : snp_top
`default_nettype wire

// ### design/snp_pkg.sv
package snp_pkg;

  localparam int CLK_MHZ = 50;

  localparam int FLASH_WAIT_US = 4500;
  localparam int EEPROM_WAIT_US = 4000;
  localparam int ERASE_WAIT_US = 9000;
  localparam int FLASH_WAIT_CYC = FLASH_WAIT_US * CLK_MHZ;
  localparam int EEPROM_WAIT_CYC = EEPROM_WAIT_US * CLK_MHZ;
  localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;
  localparam int WAIT_W = 20;

  localparam int FLASH_WORDS = 512;
  localparam int FLASH_PAGE_WORDS = 16;
  localparam int EE_BYTES = 64;
  localparam int EE_PAGE_BYTES = 4;

  localparam logic [4:0] HDR_LAST = 5'h17;
  localparam logic [4:0] CMD_LAST = 5'h1F;
  localparam logic [4:0] RD_SLOT = 5'h18;

  localparam logic [7:0] OP_ENABLE = 8'hAC;
  localparam logic [7:0] OP_ENABLE_B2 = 8'h53;
  localparam logic [2:0] ERASE_TAG = 3'h4;
  localparam logic [7:0] OP_RD_FLASH = 8'h20;
  localparam logic [7:0] OP_LD_FLASH = 8'h40;
  localparam logic [7:0] OP_WR_FLASH = 8'h4C;
  localparam logic [7:0] OP_RD_EE = 8'hA0;
  localparam logic [7:0] OP_WR_EE = 8'hC0;
  localparam logic [7:0] OP_LD_EE = 8'hC1;
  localparam logic [7:0] OP_WR_EE_PAGE = 8'hC2;
  localparam logic [7:0] OP_POLL = 8'hF0;
  localparam logic [7:0] HALF_SEL = 8'h08;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } snp_cmd_s;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WAIT} snp_state_e;

endpackage : snp_pkg

// ### design/snp_link.sv
`timescale 1ns/1ns
`default_nettype none
module snp_link (
  input wire logic sck_i,
  input wire logic prog_rst_n_i,
  input wire logic mosi_i,
  input wire logic [7:0] rd_byte_i,
  output var snp_pkg::snp_cmd_s cmd_o,
  output logic hdr_tgl_o,
  output logic cmd_tgl_o,
  output logic miso_o
);
  import snp_pkg::*;

  logic [4:0] bit_cnt;
  logic [31:0] shreg;
  logic [31:0] next_shreg;
  logic [7:0] tx;

  // new bits enter at the bottom, so the first bit sent ends up as msb
  assign next_shreg = {shreg[30:0], mosi_i};

  // a high reset pin clears the framing; sck is held low around that edge
  always_ff @(posedge sck_i or posedge prog_rst_n_i) begin
    if (prog_rst_n_i) begin
      bit_cnt <= 5'h00;
      shreg <= 32'h0;
    end else begin
      shreg <= next_shreg;
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // held words stay stable until the next command reaches its third byte
  always_ff @(posedge sck_i or posedge prog_rst_n_i) begin
    if (prog_rst_n_i) begin
      cmd_o <= '0;
      hdr_tgl_o <= 1'b0;
      cmd_tgl_o <= 1'b0;
    end else if (bit_cnt == HDR_LAST) begin
      cmd_o.b1 <= next_shreg[23:16];
      cmd_o.b2 <= next_shreg[15:8];
      cmd_o.b3 <= next_shreg[7:0];
      hdr_tgl_o <= ~hdr_tgl_o;
    end else if (bit_cnt == CMD_LAST) begin
      cmd_o <= next_shreg;
      cmd_tgl_o <= ~cmd_tgl_o;
    end
  end

  // each byte echoes the previous one; the fourth carries read data
  always_ff @(negedge sck_i or posedge prog_rst_n_i) begin
    if (prog_rst_n_i) begin
      tx <= 8'h00;
    end else if (bit_cnt[2:0] == 3'h0) begin
      if (bit_cnt == RD_SLOT) begin
        tx <= rd_byte_i;
      end else begin
        tx <= shreg[7:0];
      end
    end else begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  assign miso_o = tx[7];

endmodule : snp_link
`default_nettype wire

// ### testbench/snp_prog_model.sv
`timescale 1ns/1ns
`default_nettype none
module snp_prog_model #(
  parameter int HALF = 62,
  parameter int GAP = 300,
  parameter int ENA_WAIT = 2000
) (
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic prog_rst_n_o,
  output logic done_o,
  output logic [7:0] echo_o,
  output logic [7:0] data_o
);
  logic [31:0] rx;

  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    prog_rst_n_o = 1'b1;
    done_o = 1'b0;
    echo_o = 8'h00;
    data_o = 8'h00;
    rx = 32'h0;
  end

  // mode 0 controller; sck rests low between frames
  task automatic xfer(input logic [31:0] c);
    for (int i = 31; i >= 0; i--) begin
      mosi_o = c[i];
      #HALF sck_o = 1'b1;
      rx = {rx[30:0], miso_i};
      // long high after bit 24 so the answer byte is fetched in time
      #((i == 8) ? 3 * HALF : HALF) sck_o = 1'b0;
    end
    echo_o = rx[15:8];
    data_o = rx[7:0];
    done_o = 1'b1;
    #GAP done_o = 1'b0;
  endtask : xfer

  // sck held low across every pin change, then the start-up wait
  task automatic set_pin(input logic v);
    sck_o = 1'b0;
    // step off the clk edge that the caller may have just waited for
    #5 prog_rst_n_o = v;
    #ENA_WAIT;
  endtask : set_pin
endmodule : snp_prog_model
`default_nettype wire

// ### testbench/snp_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module snp_top_tb;
  import snp_pkg::*;
  localparam int WAIT = 1000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sck, pin_n, mosi, miso, miso_en, miso_q = 1'b0, miso_w;
  logic prog_mode, busy, normal_run, done;
  logic [7:0] echo, data;
  logic [17:0] e;
  logic [17:0] exp_q[$];
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  always #10 clk_i = ~clk_i;

  // released line shows the inverse of its last level
  always @(posedge clk_i) if (miso_en === 1'b1) miso_q <= miso;
  assign miso_w = (miso_en === 1'b1) ? miso : ~miso_q;

  snp_top #(.FLASH_WAIT(WAIT), .EEPROM_WAIT(WAIT), .ERASE_WAIT(WAIT)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .prog_rst_n_i(pin_n), .mosi_i(mosi),
    .miso_o(miso), .miso_en_o(miso_en), .prog_mode_o(prog_mode), .busy_o(busy),
    .normal_run_o(normal_run));

  snp_prog_model u_prog (
    .miso_i(miso_w), .sck_o(sck), .mosi_o(mosi), .prog_rst_n_o(pin_n), .done_o(done),
    .echo_o(echo), .data_o(data));

  task automatic finish_test;
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 100000) begin
      errors++;
      finish_test;
    end
  end

  always @(posedge done) begin
    if (exp_q.size() == 0) check("queue", 8'h00, 8'h01);
    else begin
      e = exp_q.pop_front();
      if (e[17]) check("echo", echo, e[15:8]);
      if (e[16]) check("data", data, e[7:0]);
    end
  end

  task automatic cmd(input logic [31:0] c, input logic ce, input logic cd, input logic [7:0] d);
    exp_q.push_back({ce, cd, c[23:16], d});
    u_prog.xfer(c);
  endtask : cmd

  // polling replaces the fixed waits after writes and erase
  task automatic wait_ready;
    for (int n = 0; n < 40; n++) begin
      cmd({OP_POLL, 24'h0}, 1'b1, 1'b0, 8'h00);
      if (data[0] === 1'b0) return;
    end
    check("ready", 8'h00, 8'h01);
  endtask : wait_ready

  task automatic enable;
    for (int t = 0; t < 3; t++) begin
      cmd({OP_ENABLE, OP_ENABLE_B2, 16'h0}, 1'b1, 1'b0, 8'h00);
      if (echo === OP_ENABLE_B2) return;
      u_prog.set_pin(1'b1);
      u_prog.set_pin(1'b0);
    end
  endtask : enable

  initial begin
    logic [5:0] a;
    logic [7:0] d, d2;
    logic [8:0] w;
    logic [3:0] pg;
    logic [4:0] pf;
    logic [7:0] fl[32];
    void'($urandom(32'h75E8));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("normal_run", {7'h0, normal_run}, 8'h01);
    u_prog.set_pin(1'b0);
    cmd({OP_RD_EE, 24'h0}, 1'b1, 1'b1, 8'h00);
    cmd({OP_ENABLE, 8'h80, 16'h0}, 1'b1, 1'b0, 8'h00);
    check("busy", {7'h0, busy}, 8'h00);
    check("prog_mode", {7'h0, prog_mode}, 8'h00);
    enable;
    check("prog_mode", {7'h0, prog_mode}, 8'h01);
    cmd({OP_ENABLE, 8'h80, 16'h0}, 1'b1, 1'b0, 8'h00);
    check("busy", {7'h0, busy}, 8'h01);
    wait_ready;
    a = 6'($urandom);
    w = 9'($urandom);
    d = 8'($urandom);
    d2 = 8'($urandom);
    cmd({OP_RD_EE, 8'h00, 2'b00, a, 8'h00}, 1'b1, 1'b1, ERASED_BYTE);
    cmd({OP_RD_FLASH | HALF_SEL, 7'h0, w, 8'h00}, 1'b1, 1'b1, ERASED_BYTE);
    cmd({OP_WR_EE, 8'h00, 2'b00, a, d}, 1'b1, 1'b0, 8'h00);
    cmd({OP_POLL, 24'h0}, 1'b1, 1'b1, 8'h01);
    cmd({OP_WR_EE, 8'h00, 2'b00, a, d2}, 1'b1, 1'b0, 8'h00);
    wait_ready;
    cmd({OP_RD_EE, 8'h00, 2'b00, a, 8'h00}, 1'b1, 1'b1, d);
    cmd({OP_WR_EE, 8'h00, 2'b00, a, ~d}, 1'b1, 1'b0, 8'h00);
    wait_ready;
    cmd({OP_RD_EE, 8'h00, 2'b00, a, 8'h00}, 1'b1, 1'b1, ~d);
    pg = a[5:2] + 4'h1;
    for (int i = 0; i < 4; i += 2) cmd({OP_LD_EE, 14'h0, i[1:0], d ^ i[7:0]}, 1'b1, 1'b0, 8'h00);
    cmd({OP_WR_EE_PAGE, 8'h00, 2'b00, pg, 10'h0}, 1'b1, 1'b0, 8'h00);
    wait_ready;
    for (int i = 0; i < 4; i++) begin
      cmd({OP_RD_EE, 8'h00, 2'b00, pg, i[1:0], 8'h00}, 1'b1, 1'b1,
          i[0] ? ERASED_BYTE : d ^ i[7:0]);
    end
    pf = 5'($urandom);
    for (int i = 0; i < 32; i++) begin
      fl[i] = 8'($urandom);
      cmd({OP_LD_FLASH | (i[0] ? HALF_SEL : 8'h00), 12'h0, i[4:1], fl[i]}, 1'b1, 1'b0,
          8'h00);
    end
    cmd({OP_WR_FLASH, 7'h0, pf, 12'h0}, 1'b1, 1'b0, 8'h00);
    wait_ready;
    for (int i = 0; i < 32; i++) begin
      cmd({OP_RD_FLASH | (i[0] ? HALF_SEL : 8'h00), 7'h0, pf, i[4:1], 8'h00}, 1'b1, 1'b1,
          fl[i]);
    end
    u_prog.set_pin(1'b1);
    check("normal_run", {7'h0, normal_run}, 8'h01);
    check("prog_mode", {7'h0, prog_mode}, 8'h00);
    // a write sent with the pin high must leave no trace
    cmd({OP_WR_EE, 8'h00, 2'b00, a, d}, 1'b0, 1'b0, 8'h00);
    u_prog.set_pin(1'b0);
    enable;
    cmd({OP_RD_EE, 8'h00, 2'b00, a, 8'h00}, 1'b1, 1'b1, ~d);
    finish_test;
  end
endmodule : snp_top_tb
`default_nettype wire
